// >>> hdl/bumc_addr_fmt.sv
// Forms the logged bus-unit error address from the error source and cache size.
// Assumes the physical address and way arrive with the error event.
`timescale 1ns/1ps
module bumc_addr_fmt
  import bumc_pkg::*;
(
  input  bumc_pkg::bumc_src_e    src_i,  // Error source.
  input  bumc_pkg::bumc_l2size_e size_i, // Configured cache size.
  input  wire logic [39:0]       phys_i, // Physical address.
  input  wire logic [3:0]        way_i,  // Encoded cache way.
  output logic      [63:0]       addr_o  // Address to log.
);

  logic [39:0] set_mask;

  always_comb
  begin
    case (size_i)
      L2_1MB:   set_mask = 40'h00_0000_ffc0;
      L2_512KB: set_mask = 40'h00_0000_7fc0;
      L2_256KB: set_mask = 40'h00_0000_3fc0;
      L2_128KB: set_mask = 40'h00_0000_1fc0;
      default:  set_mask = 40'h00_0000_0000;
    endcase
  end

  always_comb
  begin
    if (src_i == SRC_TAG_PARITY || src_i == SRC_TAG_ECC)
    begin
      addr_o = {24'h00_0000, (phys_i & set_mask) | {36'h0_0000_0000, way_i}}; // RQ12
    end
    else
    begin
      addr_o = {24'h00_0000, phys_i[ADDR_PHYS_HI:ADDR_LINE_LO], 6'h00}; // RQ11 RQ10
    end
  end

endmodule

// >>> hdl/bumc_mask_reg.sv
// Enable register whose bits can be barred from being set by a mask.
// Assumes write strobe and data come from logic on the same clock.
`timescale 1ns/1ps
module bumc_mask_reg #(
  parameter int unsigned W = 20
) (
  input  wire logic         clk_i,   // Core clock.
  input  wire logic         rst_n_i, // Synchronised reset, active low.
  input  wire logic         we_i,    // Write strobe.
  input  wire logic [W-1:0] wdata_i, // Write data.
  input  wire logic [W-1:0] mask_i,  // Ones bar setting the matching bit.
  output logic      [W-1:0] q_o      // Current enables.
);

  // A masked bit may still be cleared, and one already set stays set on a write of one.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q_o <= '0;
    end
    else if (we_i)
    begin
      q_o <= wdata_i & (~mask_i | q_o); // RQ7
    end
  end

endmodule

// >>> hdl/bumc_pkg.sv
// Shared constants and carriers for the bus-unit machine-check reporting block.
// Assumes a single 50 MHz core clock and model-specific register accesses from the core.
package bumc_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [31:0] BUMC_ADDR_BU_ENABLE  = 32'h0000_0408;
  localparam logic [31:0] BUMC_ADDR_BU_STATUS  = 32'h0000_0409;
  localparam logic [31:0] BUMC_ADDR_BU_ERRADDR = 32'h0000_040a;
  localparam logic [31:0] BUMC_ADDR_LS_ENABLE  = 32'h0000_040c;
  localparam logic [31:0] BUMC_ADDR_LS_STATUS  = 32'h0000_040d;
  localparam logic [31:0] BUMC_ADDR_LS_ERRADDR = 32'h0000_040e;
  localparam logic [31:0] BUMC_ADDR_BU_MASK    = 32'hc001_0046;

  // ----------------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned BUMC_BU_EN_W = 20;
  localparam int unsigned BUMC_LS_EN_W = 3;
  localparam logic [19:0] BUMC_BU_EN_RST = 20'h0_0000;
  localparam logic [2:0]  BUMC_LS_EN_RST = 3'h0;
  localparam logic [63:0] BUMC_REG_RST   = 64'h0000_0000_0000_0000;

  // Bus-unit enable bit positions.
  localparam int unsigned EN_RD_PREFETCH  = 0;
  localparam int unsigned EN_RD_TLB       = 1;
  localparam int unsigned EN_RD_ALL       = 2;
  localparam int unsigned EN_SECC1_TLB    = 3;
  localparam int unsigned EN_SECC1_PF     = 4;
  localparam int unsigned EN_SECCM_TLB    = 5;
  localparam int unsigned EN_SECCM_PF     = 6;
  localparam int unsigned EN_TPAR_FETCH   = 7;
  localparam int unsigned EN_DECC1_TLB    = 12;
  localparam int unsigned EN_DECCM_TLB    = 15;
  localparam int unsigned EN_TECC1_SCRUB  = 18;
  localparam int unsigned EN_TECCM_SCRUB  = 19;
  localparam int unsigned EN_NONE         = 31;

  // Load/store enable bit positions.
  localparam int unsigned EN_LS_LOAD  = 0;
  localparam int unsigned EN_LS_STORE = 1;

  // Status field positions.
  localparam int unsigned ST_VAL   = 63;
  localparam int unsigned ST_OVER  = 62;
  localparam int unsigned ST_UC    = 61;
  localparam int unsigned ST_EN    = 60;
  localparam int unsigned ST_ADDRESS_VALID_FLAG = 58;
  localparam int unsigned ST_PCC   = 57;
  localparam int unsigned ST_CORRECTED_ECC_FLAG  = 46;
  localparam int unsigned ST_UNCORRECTED_ECC_FLAG  = 45;
  localparam int unsigned ST_SCRUB = 40;

  // Address layout.
  localparam int unsigned ADDR_PHYS_HI = 39;
  localparam int unsigned ADDR_LINE_LO = 6;
  localparam int unsigned ADDR_WAY_W   = 4;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_SYS_READ, SRC_SYS_ECC, SRC_TAG_PARITY, SRC_TAG_ECC, SRC_DATA_ECC, SRC_ADDR_RANGE
  } bumc_src_e;

  typedef enum logic [2:0] {
    ACC_FETCH, ACC_TLB, ACC_PREFETCH, ACC_SNOOP, ACC_COPYBACK, ACC_SCRUB
  } bumc_acc_e;

  typedef enum logic [1:0] {
    L2_1MB, L2_512KB, L2_256KB, L2_128KB
  } bumc_l2size_e;

  typedef struct packed {
    logic                   valid;
    bumc_src_e              src;
    bumc_acc_e              acc;
    logic                   multi;
    logic [39:0]            phys;
    logic [3:0]             way;
  } bumc_bu_err_s;

  typedef struct packed {
    logic                   valid;
    logic                   store;
    logic                   addr_ok;
    logic [39:0]            phys;
  } bumc_ls_err_s;

  typedef struct packed {
    logic                   req;
    logic                   we;
    logic [31:0]            addr;
    logic [63:0]            wdata;
  } bumc_msr_req_s;

endpackage

// >>> hdl/bumc_top.sv
// Bus-unit and load/store machine-check reporting registers.
// Assumes error events and register accesses are synchronous to clk_i;
// the global enables come from the global control register elsewhere in the core.
`timescale 1ns/1ps

// Contract
// [RQ1] Bit 0 reports read errors on prefetch, bit 1 on TLB reload.
// [RQ2] Bit 2 reports system read errors for every operation type.
// [RQ3] Bits 3-6 report system ECC errors, single/multi, TLB/prefetch.
// [RQ4] Bits 7-11 report tag parity for fetch, TLB, snoop, copyback, scrub.
// [RQ5] Bits 12-14 single, 15-17 multi data ECC for TLB, snoop, copyback.
// [RQ6] Bits 18 and 19 report tag single and multi ECC found by scrub.
// [RQ7] A set mask bit stops writes setting the matching enable bit.
// [RQ8] Bus-unit status records the detected error in the common status layout.
// [RQ9] Error address is meaningful only while the address-valid flag is one.
// [RQ10] Logged address is at most 48 bits, valid bits depend on type.
// [RQ11] Data array and out-of-range errors log physical bits 39 to 6.
// [RQ12] Tag errors log way in bits 3-0 and size-dependent set index.
// [RQ13] Global on, local off: log the error but raise no exception.
// [RQ14] Global load/store enable off: neither log nor report load/store errors.
// [RQ15] Load/store bits 0 and 1 act only while bus-unit bit 2 is one.
// [RQ16] Load/store control bits 63-3 read zero; bit 2 plain read-write.
// [RQ17] Bus-unit errors are logged only while the global enable is set.
// [RQ18] Single-bit marks corrected, multi-bit uncorrected, scrub errors set scrub flag; code sets it only for tag parity and tag ECC errors.
module bumc_top
  import bumc_pkg::*;
(
  input  wire logic              clk_i,         // Core clock, 50 MHz.
  input  wire logic              arst_n_i,      // Asynchronous reset, active low.
  input  bumc_pkg::bumc_msr_req_s msr_i,        // Register access request.
  output logic                   msr_ack_o,     // Access answered, one-cycle pulse.
  output logic                   msr_err_o,     // Unmapped address, with ack.
  output logic      [63:0]       msr_rdata_o,   // Read data, valid with ack.
  input  wire logic              global_bus_unit_enable_i,   // Global bus-unit enable.
  input  wire logic              global_load_store_enable_i, // Global load/store enable.
  input  bumc_pkg::bumc_l2size_e l2_size_i,     // Configured cache size.
  input  bumc_pkg::bumc_bu_err_s bu_err_i,      // Bus-unit error event.
  input  bumc_pkg::bumc_ls_err_s ls_err_i,      // Load/store error event.
  output logic                   bu_mce_o,      // Bus-unit exception, one-cycle pulse.
  output logic                   ls_mce_o       // Load/store exception, one-cycle pulse.
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  logic               wr_bu_en;
  logic               wr_bu_mask;
  logic               wr_bu_st;
  logic               wr_bu_addr;
  logic               wr_ls_en;
  logic               wr_ls_st;
  logic               wr_ls_addr;
  logic               hit;
  logic [19:0]        bu_en;
  logic [19:0]        bu_mask_q;
  logic [2:0]         ls_en_q;
  logic [63:0]        bu_st_q;
  logic [63:0]        bu_addr_q;
  logic [63:0]        ls_st_q;
  logic [63:0]        ls_addr_q;
  logic [63:0]        rd_mux;

  assign wr_bu_en   = msr_i.req && msr_i.we && msr_i.addr == BUMC_ADDR_BU_ENABLE;
  assign wr_bu_mask = msr_i.req && msr_i.we && msr_i.addr == BUMC_ADDR_BU_MASK;
  assign wr_bu_st   = msr_i.req && msr_i.we && msr_i.addr == BUMC_ADDR_BU_STATUS;
  assign wr_bu_addr = msr_i.req && msr_i.we && msr_i.addr == BUMC_ADDR_BU_ERRADDR;
  assign wr_ls_en   = msr_i.req && msr_i.we && msr_i.addr == BUMC_ADDR_LS_ENABLE;
  assign wr_ls_st   = msr_i.req && msr_i.we && msr_i.addr == BUMC_ADDR_LS_STATUS;
  assign wr_ls_addr = msr_i.req && msr_i.we && msr_i.addr == BUMC_ADDR_LS_ERRADDR;

  always_comb
  begin
    hit    = 1'b1;
    rd_mux = 64'h0000_0000_0000_0000;
    case (msr_i.addr)
      BUMC_ADDR_BU_ENABLE:  rd_mux = {44'h000_0000_0000, bu_en};
      BUMC_ADDR_BU_MASK:    rd_mux = {44'h000_0000_0000, bu_mask_q};
      BUMC_ADDR_BU_STATUS:  rd_mux = bu_st_q;
      BUMC_ADDR_BU_ERRADDR: rd_mux = bu_addr_q;
      BUMC_ADDR_LS_ENABLE:  rd_mux = {61'h0, ls_en_q}; // RQ16
      BUMC_ADDR_LS_STATUS:  rd_mux = ls_st_q;
      BUMC_ADDR_LS_ERRADDR: rd_mux = ls_addr_q;
      default:              hit    = 1'b0;
    endcase
  end

  // Answer one cycle after the request; writes also answer, with zero data.
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      msr_ack_o   <= 1'b0;
      msr_err_o   <= 1'b0;
      msr_rdata_o <= BUMC_REG_RST;
    end
    else
    begin
      msr_ack_o   <= msr_i.req;
      msr_err_o   <= msr_i.req && !hit;
      msr_rdata_o <= (msr_i.req && !msr_i.we) ? rd_mux : BUMC_REG_RST;
    end
  end

  // ----------------------------------------------------------------------
  // Enable and mask registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bu_mask_q <= BUMC_BU_EN_RST;
    end
    else if (wr_bu_mask)
    begin
      bu_mask_q <= msr_i.wdata[19:0];
    end
  end

  bumc_mask_reg #(
    .W       (BUMC_BU_EN_W)
  ) u_bu_en (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .we_i    (wr_bu_en),
    .wdata_i (msr_i.wdata[19:0]),
    .mask_i  (bu_mask_q),
    .q_o     (bu_en)
  );

  // Bit 2 is kept as storage only; only the register read returns it.
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ls_en_q <= BUMC_LS_EN_RST;
    end
    else if (wr_ls_en)
    begin
      ls_en_q <= msr_i.wdata[2:0]; // RQ16
    end
  end

  // ----------------------------------------------------------------------
  // Bus-unit classification
  // ----------------------------------------------------------------------
  logic        bu_local;
  logic        bu_log;
  logic        bu_address_valid_flag;
  logic        bu_uc;
  logic        bu_pcc;
  logic        bu_ecc;
  logic        bu_scrub;
  logic [63:0] bu_addr_fmt;
  int unsigned idx;

  // Index into the enable bits; the multi-bit copy sits three above for data ECC, two for system ECC, one for tag ECC.
  always_comb
  begin
    idx = EN_NONE;
    case (bu_err_i.src)
      SRC_SYS_ECC:
        if (bu_err_i.acc == ACC_TLB)
          idx = bu_err_i.multi ? EN_SECCM_TLB : EN_SECC1_TLB; // RQ3
        else if (bu_err_i.acc == ACC_PREFETCH)
          idx = bu_err_i.multi ? EN_SECCM_PF : EN_SECC1_PF; // RQ3
      SRC_TAG_PARITY:
        // Prefetch has no tag parity enable, so the later access kinds sit one lower.
        if (bu_err_i.acc inside {ACC_FETCH, ACC_TLB})
          idx = EN_TPAR_FETCH + 32'(bu_err_i.acc); // RQ4
        else if (bu_err_i.acc inside {ACC_SNOOP, ACC_COPYBACK, ACC_SCRUB})
          idx = EN_TPAR_FETCH + 32'(bu_err_i.acc) - 32'd1; // RQ4
      SRC_TAG_ECC:
        if (bu_err_i.acc == ACC_SCRUB)
          idx = bu_err_i.multi ? EN_TECCM_SCRUB : EN_TECC1_SCRUB; // RQ6
      SRC_DATA_ECC:
        if (bu_err_i.acc inside {ACC_TLB, ACC_SNOOP, ACC_COPYBACK})
          idx = (bu_err_i.multi ? EN_DECCM_TLB : EN_DECC1_TLB)
                + 32'(bu_err_i.acc) - 32'(ACC_TLB) - (bu_err_i.acc == ACC_TLB ? 0 : 1); // RQ5
      default:
        idx = EN_NONE;
    endcase
  end

  always_comb
  begin
    if (bu_err_i.src == SRC_SYS_READ)
    begin
      bu_local = bu_en[EN_RD_ALL] // RQ2
              || (bu_err_i.acc == ACC_PREFETCH && bu_en[EN_RD_PREFETCH]) // RQ1
              || (bu_err_i.acc == ACC_TLB && bu_en[EN_RD_TLB]); // RQ1
    end
    else if (idx < BUMC_BU_EN_W)
    begin
      bu_local = bu_en[idx[4:0]];
    end
    else
    begin
      bu_local = 1'b0;
    end
  end

  assign bu_log   = bu_err_i.valid && global_bus_unit_enable_i; // RQ17
  assign bu_ecc   = bu_err_i.src inside {SRC_SYS_ECC, SRC_TAG_ECC, SRC_DATA_ECC};
  assign bu_scrub = bu_err_i.acc == ACC_SCRUB
                 && bu_err_i.src inside {SRC_TAG_PARITY, SRC_TAG_ECC}; // RQ18
  assign bu_address_valid_flag = !(bu_err_i.acc == ACC_PREFETCH
                 && bu_err_i.src inside {SRC_SYS_READ, SRC_SYS_ECC});
  assign bu_uc    = bu_ecc ? bu_err_i.multi : 1'b1;
  assign bu_pcc   = (bu_err_i.src == SRC_TAG_PARITY) ? bu_err_i.acc != ACC_SCRUB :
                    (bu_err_i.src inside {SRC_SYS_ECC, SRC_DATA_ECC}) ? bu_err_i.multi :
                    1'b0;

  bumc_addr_fmt u_fmt (
    .src_i  (bu_err_i.src),
    .size_i (l2_size_i),
    .phys_i (bu_err_i.phys),
    .way_i  (bu_err_i.way),
    .addr_o (bu_addr_fmt)
  );

  // ----------------------------------------------------------------------
  // Bus-unit logging; a logged error wins over a software write in the same cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bu_st_q   <= BUMC_REG_RST;
      bu_addr_q <= BUMC_REG_RST;
    end
    else if (bu_log)
    begin
      bu_st_q           <= BUMC_REG_RST; // RQ8
      bu_st_q[ST_VAL]   <= 1'b1;
      bu_st_q[ST_OVER]  <= bu_st_q[ST_VAL];
      bu_st_q[ST_UC]    <= bu_uc;
      bu_st_q[ST_EN]    <= bu_local;
      bu_st_q[ST_ADDRESS_VALID_FLAG] <= bu_address_valid_flag; // RQ9
      bu_st_q[ST_PCC]   <= bu_pcc;
      bu_st_q[ST_CORRECTED_ECC_FLAG]  <= bu_ecc && !bu_err_i.multi; // RQ18
      bu_st_q[ST_UNCORRECTED_ECC_FLAG]  <= bu_ecc && bu_err_i.multi; // RQ18
      bu_st_q[ST_SCRUB] <= bu_scrub;
      bu_addr_q         <= bu_address_valid_flag ? bu_addr_fmt : BUMC_REG_RST; // RQ11 RQ12
    end
    else
    begin
      if (wr_bu_st)
        bu_st_q <= msr_i.wdata;
      if (wr_bu_addr)
        bu_addr_q <= msr_i.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      bu_mce_o <= 1'b0;
    else
      bu_mce_o <= bu_log && bu_local; // RQ13 RQ17
  end

  // ----------------------------------------------------------------------
  // Load/store logging
  // ----------------------------------------------------------------------
  logic ls_local;
  logic ls_log;

  assign ls_local = bu_en[EN_RD_ALL]
                 && (ls_err_i.store ? ls_en_q[EN_LS_STORE] : ls_en_q[EN_LS_LOAD]); // RQ15
  assign ls_log   = ls_err_i.valid && global_load_store_enable_i; // RQ14

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ls_st_q   <= BUMC_REG_RST;
      ls_addr_q <= BUMC_REG_RST;
    end
    else if (ls_log)
    begin
      ls_st_q           <= BUMC_REG_RST;
      ls_st_q[ST_VAL]   <= 1'b1;
      ls_st_q[ST_OVER]  <= ls_st_q[ST_VAL];
      ls_st_q[ST_UC]    <= 1'b1;
      ls_st_q[ST_EN]    <= ls_local; // RQ13
      ls_st_q[ST_ADDRESS_VALID_FLAG] <= ls_err_i.addr_ok;
      ls_st_q[ST_PCC]   <= ls_err_i.addr_ok;
      ls_addr_q         <= {24'h00_0000, ls_err_i.phys};
    end
    else
    begin
      if (wr_ls_st)
        ls_st_q <= msr_i.wdata;
      if (wr_ls_addr)
        ls_addr_q <= msr_i.wdata;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      ls_mce_o <= 1'b0;
    else
      ls_mce_o <= ls_log && ls_local; // RQ13 RQ15
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_bu_event;
    bu_err_i.valid && global_bus_unit_enable_i;
  endsequence

  sequence s_ls_read;
    msr_i.req && !msr_i.we && msr_i.addr == BUMC_ADDR_LS_ENABLE;
  endsequence

  a_mask_blocks_set: assert property ( // RQ7
    wr_bu_en && bu_mask_q[0] && !bu_en[0] |=> !bu_en[0])
    else $error("masked enable bit was set by a write");

  a_global_bu_off: assert property ( // RQ17
    bu_err_i.valid && !global_bus_unit_enable_i && !wr_bu_st |=> $stable(bu_st_q) && !bu_mce_o)
    else $error("bus-unit error logged while globally disabled");

  a_local_off_log: assert property ( // RQ13
    s_bu_event ##0 !bu_local |=> bu_st_q[ST_VAL] && !bu_st_q[ST_EN] && !bu_mce_o)
    else $error("locally disabled error not logged quietly");

  a_prefetch_read: assert property ( // RQ1
    s_bu_event ##0 bu_err_i.src == SRC_SYS_READ && bu_err_i.acc == ACC_PREFETCH
      && bu_en[EN_RD_PREFETCH] |=> bu_mce_o)
    else $error("prefetch read error not reported");

  a_ls_global_off: assert property ( // RQ14
    ls_err_i.valid && !global_load_store_enable_i && !wr_ls_st |=> $stable(ls_st_q) && !ls_mce_o)
    else $error("load/store error logged while globally disabled");

  a_ls_needs_all: assert property ( // RQ15
    ls_mce_o |-> $past(bu_en[EN_RD_ALL]) && $past(ls_err_i.valid))
    else $error("load/store report without all-read enable");

  a_ls_read_zero: assert property ( // RQ16
    s_ls_read |=> msr_ack_o && msr_rdata_o[63:3] == 61'h0)
    else $error("load/store control upper bits not zero");

  a_ecc_marks: assert property ( // RQ18
    s_bu_event ##0 bu_err_i.src == SRC_DATA_ECC && !bu_err_i.multi
      |=> bu_st_q[ST_CORRECTED_ECC_FLAG] && !bu_st_q[ST_UNCORRECTED_ECC_FLAG] && !bu_st_q[ST_UC])
    else $error("single-bit error not marked corrected");

  a_data_addr: assert property ( // RQ11
    s_bu_event ##0 bu_err_i.src == SRC_DATA_ECC ##1 1'b1
      |-> bu_addr_q[39:6] == $past(bu_err_i.phys[39:6]) && bu_st_q[ST_ADDRESS_VALID_FLAG])
    else $error("data array error address wrong");

  a_tag_way: assert property ( // RQ12
    s_bu_event ##0 bu_err_i.src == SRC_TAG_PARITY |=> bu_addr_q[3:0] == $past(bu_err_i.way)
      && bu_addr_q[63:16] == 48'h0)
    else $error("tag error address wrong");

endmodule

// >>> tb/bumc_top_tb.sv
// Self-checking bench for the bus-unit and load/store machine-check registers.
// Assumes the register port answers one cycle after each request, as the hand-over states.
`timescale 1ns/1ps
module bumc_top_tb;
  import bumc_pkg::*;

  // ----------------------------------------------------------------------
  // Stimulus and expectations
  // ----------------------------------------------------------------------
  typedef struct {
    bumc_src_e   s;
    bumc_acc_e   a;
    logic        m;
    int unsigned b;
    logic        mce;
  } bumc_row_s;

  localparam logic [63:0] ST_CHK = 64'h9000_6100_0000_0000;
  localparam logic [39:0] PHYS   = 40'h12_3456_7890;

  logic          clk_i;
  logic          arst_n_i;
  bumc_msr_req_s req;
  logic          ack;
  logic          msr_err;
  logic [63:0]   rdata;
  logic          g_bu;
  logic          g_ls;
  bumc_l2size_e  l2_size;
  bumc_bu_err_s  bu_err;
  bumc_ls_err_s  ls_err;
  logic          bu_mce;
  logic          ls_mce;
  logic [63:0]   rd;
  int            bad_count;
  int            total_checks;
  bumc_row_s     rows [21] = '{
    '{SRC_SYS_READ, ACC_PREFETCH, 1'b0, 0, 1'b1}, '{SRC_SYS_READ, ACC_TLB, 1'b0, 1, 1'b1},
    '{SRC_SYS_READ, ACC_FETCH, 1'b0, 2, 1'b1}, '{SRC_SYS_READ, ACC_FETCH, 1'b0, 0, 1'b0},
    '{SRC_SYS_ECC, ACC_TLB, 1'b0, 3, 1'b1}, '{SRC_SYS_ECC, ACC_PREFETCH, 1'b0, 4, 1'b1},
    '{SRC_SYS_ECC, ACC_TLB, 1'b1, 5, 1'b1}, '{SRC_SYS_ECC, ACC_PREFETCH, 1'b1, 6, 1'b1},
    '{SRC_TAG_PARITY, ACC_FETCH, 1'b0, 7, 1'b1}, '{SRC_TAG_PARITY, ACC_TLB, 1'b0, 8, 1'b1},
    '{SRC_TAG_PARITY, ACC_SNOOP, 1'b0, 9, 1'b1}, '{SRC_TAG_PARITY, ACC_COPYBACK, 1'b0, 10, 1'b1},
    '{SRC_TAG_PARITY, ACC_SCRUB, 1'b0, 11, 1'b1}, '{SRC_DATA_ECC, ACC_TLB, 1'b0, 12, 1'b1},
    '{SRC_DATA_ECC, ACC_SNOOP, 1'b0, 13, 1'b1}, '{SRC_DATA_ECC, ACC_COPYBACK, 1'b0, 14, 1'b1},
    '{SRC_DATA_ECC, ACC_TLB, 1'b1, 15, 1'b1}, '{SRC_DATA_ECC, ACC_SNOOP, 1'b1, 16, 1'b1},
    '{SRC_DATA_ECC, ACC_COPYBACK, 1'b1, 17, 1'b1}, '{SRC_TAG_ECC, ACC_SCRUB, 1'b0, 18, 1'b1},
    '{SRC_TAG_ECC, ACC_SCRUB, 1'b1, 18, 1'b0}};

  bumc_top bumc_top_i (
    .clk_i                      (clk_i),
    .arst_n_i                   (arst_n_i),
    .msr_i                      (req),
    .msr_ack_o                  (ack),
    .msr_err_o                  (msr_err),
    .msr_rdata_o                (rdata),
    .global_bus_unit_enable_i   (g_bu),
    .global_load_store_enable_i (g_ls),
    .l2_size_i                  (l2_size),
    .bu_err_i                   (bu_err),
    .ls_err_i                   (ls_err),
    .bu_mce_o                   (bu_mce),
    .ls_mce_o                   (ls_mce)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // The request stays up for exactly the one edge that takes it.
  task automatic msr(input logic we, input logic [31:0] a, input logic [63:0] d);
    @(posedge clk_i) #1 req = '{1'b1, we, a, d};
    @(posedge clk_i) #1 req.req = 1'b0;
    chk("msr_ack", 64'h1, {63'h0, ack});
    rd = rdata;
  endtask

  task automatic bu_ev(input bumc_src_e s, input bumc_acc_e a, input logic m,
                       input logic [39:0] p);
    @(posedge clk_i) #1 bu_err = '{1'b1, s, a, m, p, 4'hA};
    @(posedge clk_i) #1 bu_err.valid = 1'b0;
  endtask

  task automatic ls_ev(input logic st);
    @(posedge clk_i) #1 ls_err = '{1'b1, st, 1'b1, PHYS};
    @(posedge clk_i) #1 ls_err.valid = 1'b0;
  endtask

  function automatic logic [63:0] exp_st(input bumc_row_s r);
    logic ecc;
    logic [63:0] st;
    ecc = (r.s == SRC_SYS_ECC) || (r.s == SRC_TAG_ECC) || (r.s == SRC_DATA_ECC);
    st = 64'h0;
    st[ST_VAL] = 1'b1;
    st[ST_EN] = r.mce;
    st[ST_CORRECTED_ECC_FLAG] = ecc & ~r.m;
    st[ST_UNCORRECTED_ECC_FLAG] = ecc & r.m;
    st[ST_SCRUB] = (r.a == ACC_SCRUB);
    return st;
  endfunction

  task automatic end_of_test();
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #1_000_000;
    bad_count++;
    end_of_test();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    bad_count = 0;
    total_checks = 0;
    arst_n_i = 1'b0;
    req = '0;
    g_bu = 1'b1;
    g_ls = 1'b1;
    l2_size = L2_1MB;
    bu_err = '0;
    ls_err = '0;
    repeat (5) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    repeat (2) @(posedge clk_i);
    // Ordinary cases: one enable bit alone, then one event of its class; two rows pair the bit with an event it does not cover.
    foreach (rows[i])
    begin
      msr(1'b1, BUMC_ADDR_BU_ENABLE, 64'h1 << rows[i].b);
      msr(1'b1, BUMC_ADDR_BU_STATUS, 64'h0);
      bu_ev(rows[i].s, rows[i].a, rows[i].m, PHYS);
      chk("bu_mce", {63'h0, rows[i].mce}, {63'h0, bu_mce});
      msr(1'b0, BUMC_ADDR_BU_STATUS, 64'h0);
      chk("bu_status", exp_st(rows[i]), rd & ST_CHK);
      msr(1'b0, BUMC_ADDR_BU_ERRADDR, 64'h0);
      if (rows[i].s == SRC_DATA_ECC)
        chk("bu_addr", {24'h0, PHYS[39:6], 6'h0}, rd);
    end
    // Register access kinds and the mask.
    msr(1'b1, BUMC_ADDR_LS_ENABLE, 64'hFFFF_FFFF_FFFF_FFFF);
    msr(1'b0, BUMC_ADDR_LS_ENABLE, 64'h0);
    chk("ls_enable", 64'h7, rd);
    msr(1'b0, 32'h0000_0407, 64'h0);
    chk("unmapped_err", 64'h1, {63'h0, msr_err});
    chk("unmapped_rdata", 64'h0, rd);
    msr(1'b1, BUMC_ADDR_BU_ENABLE, 64'h0);
    msr(1'b1, BUMC_ADDR_BU_MASK, 64'h1);
    msr(1'b1, BUMC_ADDR_BU_ENABLE, 64'hF_FFFF);
    msr(1'b0, BUMC_ADDR_BU_ENABLE, 64'h0);
    chk("masked_enable", 64'hF_FFFE, rd);
    msr(1'b1, BUMC_ADDR_BU_MASK, 64'hF_FFFE);
    msr(1'b1, BUMC_ADDR_BU_ENABLE, 64'hF_FFFF);
    msr(1'b0, BUMC_ADDR_BU_ENABLE, 64'h0);
    chk("kept_enable", 64'hF_FFFF, rd);
    msr(1'b1, BUMC_ADDR_BU_MASK, 64'h0);
    // Global enable off: nothing logged even with every local enable on.
    msr(1'b1, BUMC_ADDR_BU_STATUS, 64'h0);
    g_bu = 1'b0;
    bu_ev(SRC_SYS_READ, ACC_PREFETCH, 1'b0, PHYS);
    chk("bu_mce_off", 64'h0, {63'h0, bu_mce});
    msr(1'b0, BUMC_ADDR_BU_STATUS, 64'h0);
    chk("bu_status_off", 64'h0, rd);
    g_bu = 1'b1;
    // Tag errors keep only the set index for each cache size, plus the way.
    for (int s = 0; s < 4; s++)
    begin
      l2_size = bumc_l2size_e'(s);
      bu_ev(SRC_TAG_PARITY, ACC_FETCH, 1'b0, 40'hFF_FFFF_FFFF);
      msr(1'b0, BUMC_ADDR_BU_STATUS, 64'h0);
      chk("tag_address_valid_flag", 64'h1, {63'h0, rd[ST_ADDRESS_VALID_FLAG]});
      msr(1'b0, BUMC_ADDR_BU_ERRADDR, 64'h0);
      chk("tag_addr", ((64'h1 << (16 - s)) - 64'h40) | 64'hA, rd);
    end
    bu_ev(SRC_ADDR_RANGE, ACC_FETCH, 1'b0, 40'hAB_CDEF_1234);
    msr(1'b0, BUMC_ADDR_BU_ERRADDR, 64'h0);
    chk("range_addr", {24'h0, 34'h2_AF37_BC48, 6'h0}, rd);
    // Load/store reporting hangs on its own bits and on the all-read enable.
    msr(1'b1, BUMC_ADDR_BU_ENABLE, 64'h4);
    msr(1'b1, BUMC_ADDR_LS_ENABLE, 64'h1);
    ls_ev(1'b0);
    chk("ls_mce_load", 64'h1, {63'h0, ls_mce});
    msr(1'b1, BUMC_ADDR_LS_STATUS, 64'h0);
    ls_ev(1'b1);
    chk("ls_mce_store", 64'h0, {63'h0, ls_mce});
    msr(1'b0, BUMC_ADDR_LS_STATUS, 64'h0);
    chk("ls_logged", 64'h1, {63'h0, rd[ST_VAL]});
    msr(1'b1, BUMC_ADDR_LS_STATUS, 64'h0);
    g_ls = 1'b0;
    ls_ev(1'b0);
    chk("ls_mce_off", 64'h0, {63'h0, ls_mce});
    msr(1'b0, BUMC_ADDR_LS_STATUS, 64'h0);
    chk("ls_status_off", 64'h0, rd);
    g_ls = 1'b1;
    msr(1'b1, BUMC_ADDR_BU_ENABLE, 64'h0);
    msr(1'b1, BUMC_ADDR_LS_ENABLE, 64'h3);
    ls_ev(1'b0);
    chk("ls_mce_no_all", 64'h0, {63'h0, ls_mce});
    // A second reset in mid-run clears the enables again.
    @(posedge clk_i) #1 arst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 arst_n_i = 1'b1;
    repeat (2) @(posedge clk_i);
    msr(1'b0, BUMC_ADDR_LS_ENABLE, 64'h0);
    chk("ls_enable_rst", 64'h0, rd);
    end_of_test();
  end
endmodule
